// file: design/asf_pkg.sv
// Functional notes
// [R1] Frame select falling starts a serial frame; its rising edge ends it.
// [R2] Host gives a whole multiple of 16 rising clocks per frame.
// [R3] Result pin floats while frame select is high, driven while low.
// [R4] Serial clock is ignored while frame select is high.
// [R5] First three serial-clock cycles of each conversion are track mode.
// [R6] Next thirteen cycles convert and shift; sixteen cycles per conversion.
// [R7] Falling edges one to four put out zero bits.
// [R8] Falling edges five to fourteen put out the result, MSB first.
// [R9] Falling edges fifteen and sixteen put out trailing zeros.
// [R10] Track mode restarts on the fall after every sixteenth rise.
// [R11] Each later slot goes back to hold on its fourth fall.
// [R12] Select falling with clock high: track starts on next clock fall.
// [R13] Select falling with clock low: track at once, counts as fall one.
// [R14] The input is sampled on the fourth falling edge of a conversion.
// [R15] Host sends a fresh command word in every conversion slot.
// [R16] Command word taken on first eight rising edges, MSB first.
// [R17] Command bits five to three pick the channel; other bits ignored.
// [R18] Channel selection resets to zero, so first conversion uses input zero.
// [R19] Host samples each result bit on the rise after its launch.
package asf_pkg;

    localparam int         CNT_W       = 5;
    localparam logic [4:0] SLOT_EDGES  = 5'h10;
    localparam logic [4:0] TRACK_EDGES = 5'h03;
    localparam logic [4:0] HOLD_EDGE   = 5'h04;
    localparam logic [4:0] DATA_FIRST  = 5'h05;
    localparam int         RESULT_BITS = 10;
    localparam int         CMD_BITS    = 8;
    localparam logic [4:0] CMD_LAST    = 5'h07;
    localparam int         CHAN_MSB    = 5;
    localparam int         CHAN_LSB    = 3;
    localparam logic [2:0] CHAN_RESET  = 3'h0;
    localparam logic       SEL_N_RESET = 1'h1;
    localparam logic       SCLK_RESET  = 1'h0;

    // One-hot sequencing states.
    typedef enum logic [3:0]
    {
        ASF_IDLE  = 4'h1,
        ASF_WAIT  = 4'h2,
        ASF_TRACK = 4'h4,
        ASF_CONV  = 4'h8
    } asf_state_t;

endpackage

// file: design/asf_edge.sv
`timescale 1ns/1ps
module asf_edge #(
    parameter int         W         = 2,
    parameter logic [1:0] RESET_VAL = 2'h0
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Sampled levels.
    input  wire logic [W-1:0] level,
    // Edge pulses, one core clock wide.
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] level_q;

    if (W < 1 || W > 2)
    begin : g_bad_w
        $error("asf_edge: W must be 1 or 2");
    end

    // Previous level; reset value chosen so no false edge appears after reset.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            level_q <= RESET_VAL[W-1:0];
        else
            level_q <= level;
    end

    assign rise = level & ~level_q;
    assign fall = ~level & level_q;
endmodule

// file: design/asf_sequencer.sv
`timescale 1ns/1ps
module asf_sequencer #(
    parameter int RESULT_W = asf_pkg::RESULT_BITS
) (
    // Clock and reset.
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Serial host pins.
    input  wire logic                frame_sel_n,
    input  wire logic                sclk,
    input  wire logic                cmd_in,
    output logic                     result_out,
    output logic                     result_oe_n,
    // Converter front end.
    output logic                     track_mode,
    output logic                     hold_strobe,
    output logic                     channel_sel_bit2,
    output logic                     channel_sel_bit1,
    output logic                     channel_sel_bit0,
    input  wire logic [RESULT_W-1:0] sar_result
);
    import asf_pkg::*;

    logic [1:0]          edge_rise;
    logic [1:0]          edge_fall;
    logic                frame_start;
    logic                active;
    logic                sclk_rise_g;
    logic                sclk_fall_g;
    logic                slot_wrap;
    logic                new_fall;
    logic                hold_edge;
    logic                cmd_take;
    logic                cmd_done;
    logic [CNT_W-1:0]    fall_cnt_d;
    logic [CNT_W-1:0]    fall_cnt_q;
    logic [CNT_W-1:0]    rise_cnt_d;
    logic [CNT_W-1:0]    rise_cnt_q;
    logic [CMD_BITS-1:0] cmd_word;
    logic [CMD_BITS-1:0] cmd_shift_q;
    logic [2:0]          cmd_chan;
    logic [2:0]          chan_next_q;
    logic [2:0]          chan_cur_q;
    logic [RESULT_W-1:0] result_q;
    logic                dout_d;
    logic                dout_q;
    logic                hold_q;
    asf_state_t          st_d;
    asf_state_t          st_q;

    // The result must fit between the leading zeros and the end of the slot.
    if (RESULT_W < 1 || RESULT_W > 12)
    begin : g_bad_width
        $error("asf_sequencer: RESULT_W must lie between 1 and 12");
    end

    // Bit carried on a given falling edge of the slot; zero outside the data window.
    function automatic logic slot_bit(input logic [CNT_W-1:0] edge_n,
                                      input logic [RESULT_W-1:0] word);
        int idx;
        idx = int'(edge_n) - int'(DATA_FIRST);
        if (idx >= 0 && idx < RESULT_W)
            return word[RESULT_W - 1 - idx];
        else
            return 1'b0;
    endfunction

    // Edge detection of select (bit 0) and serial clock (bit 1) on the core clock.
    asf_edge #(
        .W         (2),
        .RESET_VAL ({SCLK_RESET, SEL_N_RESET})
    ) u_edge (
        .core_clk (core_clk),
        .rst      (rst),
        .level    ({sclk, frame_sel_n}),
        .rise     (edge_rise),
        .fall     (edge_fall)
    );

    // Framing: select low is the frame, select high discards the clock.
    assign frame_start = edge_fall[0];                        // [R1]
    assign active      = ~frame_sel_n;                        // [R1]
    assign sclk_rise_g = active & ~frame_start & edge_rise[1]; // [R4]
    assign sclk_fall_g = active & ~frame_start & edge_fall[1]; // [R4]

    // A fall after the sixteenth rise opens the next conversion slot.
    assign slot_wrap = sclk_fall_g & (rise_cnt_q == SLOT_EDGES);          // [R10]
    // Select falling onto a low clock stands in for the first clock fall.
    assign new_fall  = (frame_start & ~sclk) | sclk_fall_g;               // [R13]
    assign hold_edge = sclk_fall_g & (fall_cnt_d == HOLD_EDGE);           // [R14] [R11]

    // Falling-edge position within the slot, 1 to 16, 0 before the first.
    assign fall_cnt_d = frame_sel_n ? '0 :
                        frame_start ? (sclk ? '0 : 5'h01) :               // [R12] [R13]
                        slot_wrap   ? 5'h01 :                             // [R10]
                        (sclk_fall_g && fall_cnt_q != SLOT_EDGES) ?
                            fall_cnt_q + 5'h01 : fall_cnt_q;              // [R6]

    // Rising-edge count within the slot; it drives command capture and wrap.
    assign rise_cnt_d = (frame_sel_n || frame_start || slot_wrap) ? '0 :
                        (sclk_rise_g && rise_cnt_q != SLOT_EDGES) ?
                            rise_cnt_q + 5'h01 : rise_cnt_q;

    // Command bits arrive MSB first on the first eight rises of a slot.
    assign cmd_take = sclk_rise_g & (rise_cnt_q < 5'(CMD_BITS));           // [R16]
    assign cmd_done = sclk_rise_g & (rise_cnt_q == CMD_LAST);              // [R16]
    assign cmd_word = {cmd_shift_q[CMD_BITS-2:0], cmd_in};
    assign cmd_chan = cmd_word[CHAN_MSB:CHAN_LSB];                         // [R17]

    // Output bit for the edge being taken now; idle frames send zero.
    assign dout_d = frame_sel_n ? 1'b0 :
                    new_fall    ? slot_bit(fall_cnt_d, result_q) :         // [R7] [R8] [R9]
                    dout_q;

    // Sequencing of track and hold within each slot.
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ASF_IDLE:
            begin
                if (frame_start)
                    st_d = sclk ? ASF_WAIT : ASF_TRACK;                    // [R12] [R13]
            end
            ASF_WAIT:
            begin
                if (frame_sel_n)
                    st_d = ASF_IDLE;
                else if (new_fall)
                    st_d = ASF_TRACK;                                      // [R12]
            end
            ASF_TRACK:
            begin
                if (frame_sel_n)
                    st_d = ASF_IDLE;
                else if (hold_edge)
                    st_d = ASF_CONV;                                       // [R5] [R11]
            end
            ASF_CONV:
            begin
                if (frame_sel_n)
                    st_d = ASF_IDLE;
                else if (slot_wrap)
                    st_d = ASF_TRACK;                                      // [R10]
            end
            default:
            begin
                st_d = ASF_IDLE;
            end
        endcase
    end

    // Sequencer state and slot counters.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q       <= ASF_IDLE;
            fall_cnt_q <= '0;
            rise_cnt_q <= '0;
        end
        else
        begin
            st_q       <= st_d;
            fall_cnt_q <= fall_cnt_d;
            rise_cnt_q <= rise_cnt_d;
        end
    end

    // Command shifter; a short frame leaves the last full channel in force.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cmd_shift_q <= '0;
        else if (cmd_take)
            cmd_shift_q <= cmd_word;                                       // [R16]
    end

    // Channel for the next slot, and the one in use for the present slot.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            chan_next_q <= CHAN_RESET;                                     // [R18]
            chan_cur_q  <= CHAN_RESET;                                     // [R18]
        end
        else
        begin
            if (cmd_done)
                chan_next_q <= cmd_chan;                                   // [R17]
            if (new_fall && fall_cnt_d == 5'h01)
                chan_cur_q <= chan_next_q;
        end
    end

    // Result is frozen at the hold edge so shifting never sees it change.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            result_q <= '0;
            hold_q   <= 1'b0;
            dout_q   <= 1'b0;
        end
        else
        begin
            if (hold_edge)
                result_q <= sar_result;                                    // [R14]
            hold_q <= hold_edge;                                           // [R14]
            dout_q <= dout_d;
        end
    end

    // Pin and front-end outputs.
    assign result_out       = dout_q;
    assign result_oe_n      = frame_sel_n;                                 // [R3]
    assign track_mode       = (st_q == ASF_TRACK);                         // [R5]
    assign hold_strobe      = hold_q;
    assign channel_sel_bit2 = chan_cur_q[2];
    assign channel_sel_bit1 = chan_cur_q[1];
    assign channel_sel_bit0 = chan_cur_q[0];

    // Checks on the sequencing, all in the core clock domain.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Bit that the slot position just reached should carry on the pin.
    logic exp_bit;
    assign exp_bit = slot_bit(fall_cnt_q, result_q);

    a_oe_tracks_sel: assert property (result_oe_n == frame_sel_n) // [R3]
        else $error("result pin enable does not follow frame select");

    a_idle_ignores_clk: assert property ( // [R4]
        frame_sel_n |=> (fall_cnt_q == '0 && rise_cnt_q == '0 && !track_mode))
        else $error("serial clock counted while frame select high");

    a_start_clk_low: assert property ( // [R13]
        (frame_start && !sclk) |=> (fall_cnt_q == 5'h01 && track_mode && !result_out))
        else $error("select fall on low clock did not enter track");

    a_start_clk_high: assert property ( // [R12]
        (frame_start && sclk) |=> (fall_cnt_q == '0 && !track_mode))
        else $error("select fall on high clock entered track too soon");

    // Only the waiting state has a live frame with no fall counted yet.
    a_wait_first_fall: assert property ( // [R12]
        (!frame_sel_n && fall_cnt_q == '0 && sclk_fall_g)
        |=> (track_mode && fall_cnt_q == 5'h01))
        else $error("first clock fall after select did not enter track");

    a_track_to_hold: assert property ( // [R5]
        (track_mode && sclk_fall_g && fall_cnt_q == TRACK_EDGES)
        |=> (!track_mode && hold_strobe && fall_cnt_q == HOLD_EDGE))
        else $error("track phase did not end on the fourth fall");

    a_hold_only_fourth: assert property ( // [R11]
        $fell(track_mode) && !frame_sel_n |-> fall_cnt_q == HOLD_EDGE)
        else $error("hold entered on a fall other than the fourth");

    a_lead_zeros: assert property ( // [R7]
        (active && $changed(fall_cnt_q) && fall_cnt_q inside {[1:4]}) |-> !result_out)
        else $error("leading bit not zero");

    a_data_bits: assert property ( // [R8]
        (active && $changed(fall_cnt_q) && fall_cnt_q >= DATA_FIRST)
        |-> result_out == exp_bit)
        else $error("result bit out of order");

    a_trail_zeros: assert property ( // [R9]
        (active && $changed(fall_cnt_q) && fall_cnt_q > 5'h0E) |-> !result_out)
        else $error("trailing bit not zero");

    a_slot_restart: assert property ( // [R10]
        slot_wrap |=> (fall_cnt_q == 5'h01 && rise_cnt_q == '0 && track_mode)
        ##3 (!sclk_fall_g || track_mode))
        else $error("new slot did not restart track mode");

    a_count_range: assert property ( // [R6]
        fall_cnt_q <= SLOT_EDGES && rise_cnt_q <= SLOT_EDGES)
        else $error("slot counter ran past sixteen");

    a_frame_end: assert property ( // [R1]
        $rose(frame_sel_n) |=> (!track_mode && !result_out && fall_cnt_q == '0))
        else $error("frame end did not return the sequencer to idle");

    a_hold_single: assert property ( // [R14]
        hold_strobe |=> !hold_strobe)
        else $error("hold strobe wider than one cycle");

    a_sample_edge: assert property ( // [R14]
        hold_strobe |-> ($past(sar_result) == result_q && fall_cnt_q == HOLD_EDGE))
        else $error("sample not taken at the fourth fall");

    a_cmd_channel: assert property ( // [R17]
        cmd_done |=> chan_next_q == $past(cmd_chan))
        else $error("channel field not taken from command bits five to three");

endmodule

// file: verif/asf_host_model.sv
`timescale 1ns/1ps
module asf_host_model
(
    // Clock.
    input  wire logic       core_clk,
    // Host pins.
    output logic            frame_sel_n,
    output logic            sclk,
    output logic            cmd_in,
    // Device outputs seen by the host.
    input  wire logic       result_out,
    input  wire logic       result_oe_n,
    input  wire logic       track_mode,
    input  wire logic       hold_strobe,
    input  wire logic [2:0] chan
);
    logic [7:0]  cmd_a  [8];
    logic [15:0] word_a [8];
    logic [15:0] trk_a  [8];
    logic [15:0] oe_a   [8];
    logic [2:0]  chan_a [8];
    logic [7:0]  holds;

    // Idle pins at time zero; the clock starts low and each frame ends with it low.
    initial
    begin
        frame_sel_n = 1'h1;
        sclk = 1'h0;
        cmd_in = 1'h0;
        holds = 8'h00;
    end

    // Waits whole core cycles and counts hold pulses on the way.
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            if (hold_strobe === 1'h1)
                holds = holds + 8'h01;
        end
    endtask

    // Clock and command toggling with the select high, which must be ignored.
    task automatic toggle(input int n);
        repeat (n)
        begin
            tick(3);
            sclk <= ~sclk;
            cmd_in <= ~cmd_in;
        end
        tick(3);
        sclk <= 1'h0;
        tick(3);
    endtask

    // One frame of n slots; hi picks the clock level at the select fall.
    task automatic frame(input logic hi, input int n);
        holds = 8'h00;
        sclk <= hi;
        tick(3);
        frame_sel_n <= 1'h0;
        cmd_in <= cmd_a[0][7];
        for (int s = 0; s < n; s++)
            for (int k = 0; k < 16; k++)
            begin
                if (s > 0 || k > 0 || hi)
                begin
                    tick(3);
                    sclk <= 1'h0;
                    // Unused command slots carry a changing pattern, not a stale bit.
                    cmd_in <= (k < 8) ? cmd_a[s][7-k] : ~cmd_in;
                end
                tick(3);
                sclk <= 1'h1;
                word_a[s][15-k] = result_out;
                trk_a[s][k] = track_mode;
                oe_a[s][k] = result_oe_n;
                if (k == 0)
                    chan_a[s] = chan;
            end
        tick(3);
        frame_sel_n <= 1'h1;
        sclk <= 1'h0;
        tick(3);
    endtask
endmodule

// file: verif/asf_sequencer_bench.sv
`timescale 1ns/1ps
module asf_sequencer_bench;
    import asf_pkg::*;
    logic                   core_clk;
    logic                   rst;
    logic                   frame_sel_n;
    logic                   sclk;
    logic                   cmd_in;
    logic                   result_out;
    logic                   result_oe_n;
    logic                   track_mode;
    logic                   hold_strobe;
    logic                   channel_sel_bit2;
    logic                   channel_sel_bit1;
    logic                   channel_sel_bit0;
    logic [RESULT_BITS-1:0] sar_result;
    logic [2:0]             exp_chan;
    int                     mismatches;
    int                     tests_run;

    // The result pin floats whenever the device lets go of it.
    wire dout_pin = result_oe_n ? 1'hZ : result_out;
    wire [2:0] chan = {channel_sel_bit2, channel_sel_bit1, channel_sel_bit0};

    // Free-running core clock.
    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    asf_sequencer uut (.core_clk(core_clk), .rst(rst), .frame_sel_n(frame_sel_n),
        .sclk(sclk), .cmd_in(cmd_in), .result_out(result_out), .result_oe_n(result_oe_n),
        .track_mode(track_mode), .hold_strobe(hold_strobe),
        .channel_sel_bit2(channel_sel_bit2), .channel_sel_bit1(channel_sel_bit1),
        .channel_sel_bit0(channel_sel_bit0), .sar_result(sar_result));

    asf_host_model host (.core_clk(core_clk), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .cmd_in(cmd_in), .result_out(result_out), .result_oe_n(result_oe_n),
        .track_mode(track_mode), .hold_strobe(hold_strobe), .chan(chan));

    task automatic end_sim();
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: word got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: channel got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: pin got %b expected %b", $time, got, exp);
        end
    endtask

    // Judges each slot the host recorded; the channel follows the prior command.
    task automatic check_frame(input int n);
        logic [15:0] w;
        w = {4'h0, sar_result, 2'h0};
        for (int s = 0; s < n; s++)
        begin
            chk16(host.word_a[s], w);
            chk16(host.trk_a[s], 16'h0007);
            chk16(host.oe_a[s], 16'h0000);
            chk3(host.chan_a[s], exp_chan);
            exp_chan = host.cmd_a[s][5:3];
        end
        chk16({8'h00, host.holds}, n[15:0]);
        chk1(dout_pin, 1'hZ);
    endtask

    task automatic run(input logic hi, input int n, input logic [9:0] sar);
        @(posedge core_clk);
        sar_result <= sar;
        host.frame(hi, n);
        check_frame(n);
    endtask

    task automatic sc_first_conv();
        host.cmd_a[0] = 8'h28;
        run(1'h0, 1, 10'h2A5);
    endtask

    task automatic sc_clock_high();
        host.cmd_a[0] = 8'h10;
        run(1'h1, 1, 10'h15A);
    endtask

    // Every channel code once, with the ignored bits set around it.
    task automatic sc_all_channels();
        for (int s = 0; s < 8; s++)
            host.cmd_a[s] = 8'hC7 | 8'((((s * 3) + 1) % 8) << 3);
        run(1'h0, 8, 10'h201);
    endtask

    // Clock activity with the select high must leave the pin floating.
    // The last slot's channel (from slot six's command) must stay in force.
    task automatic sc_gated();
        host.toggle(7);
        chk1(dout_pin, 1'hZ);
        chk3(chan, host.cmd_a[6][5:3]);
        host.cmd_a[0] = 8'h00;
        run(1'h1, 1, 10'h3FF);
    endtask

    // Bounded run time so a stuck sequence still reaches the verdict.
    initial
    begin
        repeat (50000) @(posedge core_clk);
        mismatches++;
        end_sim();
    end

    initial
    begin
        mismatches = 0;
        tests_run = 0;
        rst = 1'h1;
        sar_result = 10'h000;
        exp_chan = CHAN_RESET;
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        repeat (2) @(posedge core_clk);
        sc_first_conv();
        sc_clock_high();
        sc_all_channels();
        sc_gated();
        end_sim();
    end
endmodule
